// ---- common/acrc_pkg.sv ----
package acrc_pkg;
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_POWER = 8'h08;
  localparam logic [7:0] ADDR_P_OFF = 8'h0C;
  localparam logic [7:0] ADDR_P_GAIN = 8'h10;
  localparam logic [7:0] ADDR_A_OFF = 8'h14;
  localparam logic [7:0] ADDR_A_GAIN = 8'h18;
  localparam logic [7:0] ADDR_P_DATA = 8'h1C;
  localparam logic [7:0] ADDR_A_DATA = 8'h20;
  localparam logic [7:0] OP_RESET_A = 8'h06;
  localparam logic [7:0] OP_RESET_B = 8'h07;
  localparam logic [7:0] OP_P_GCAL = 8'h17;
  localparam logic [7:0] OP_A_GCAL = 8'h1C;
  localparam int STATUS_FLAG_BIT = 0;
  localparam int STATUS_PBUSY_BIT = 1;
  localparam int STATUS_ABUSY_BIT = 2;
  localparam int POWER_FLAG_BIT = 4;
  localparam logic [23:0] P_OFF_RST = 24'h000000;
  localparam logic [23:0] P_GAIN_RST = 24'h400000;
  localparam logic [15:0] A_OFF_RST = 16'h0000;
  localparam logic [15:0] A_GAIN_RST = 16'h4000;
  localparam int P_DW = 32;
  localparam int P_CW = 24;
  localparam int P_NFS = 22;
  localparam int A_DW = 24;
  localparam int A_CW = 16;
  localparam int A_NFS = 14;
  localparam int CAL_AVG_N = 16;
  localparam int CAL_AVG_SHIFT = 4;
  localparam int RST_MIN_TICKS = 4;
  localparam int PWDN_TICKS = 65536;
  localparam int POR_TICKS = 65536;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [23:0] p_off;
    logic [23:0] p_gain;
    logic [15:0] a_off;
    logic [15:0] a_gain;
  } acrc_coeff_t;

  typedef enum logic [1:0] {CAL_IDLE, CAL_AVG, CAL_DIV} acrc_cal_st_t;
  typedef enum logic [1:0] {RS_POR, RS_RUN, RS_PINLOW, RS_PWDN} acrc_rst_st_t;
endpackage

// ---- rtl/acrc_cal_unit.sv ----
`timescale 1ns/1ps
module acrc_cal_unit
  import acrc_pkg::*;
#(
  parameter int DW = 32,
  parameter int CW = 24,
  parameter int NFS = 22
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic smp_vld,
  input wire logic [DW-1:0] smp,
  input wire logic [CW-1:0] off,
  input wire logic [CW-1:0] gain,
  input wire logic cal_go,
  output logic out_vld,
  output logic [DW-1:0] out_data,
  output logic busy,
  output logic cf_vld,
  output logic [CW-1:0] cf
);
  localparam int NW = DW - 1 + NFS;
  localparam int AW = DW + 5;

  if (CW > DW || NFS >= CW || NW > 127) $error("acrc_cal_unit: unsupported widths");

  acrc_cal_st_t st_reg, st_next;
  logic [6:0] cnt_reg, cnt_next;
  logic signed [AW-1:0] acc_reg, acc_next, sum;
  logic [NW-1:0] num_reg, num_next, q_reg, q_next;
  logic [DW:0] rem_reg, rem_next, dv_reg, dv_next, trial;
  logic out_vld_next, cf_vld_next;
  logic [DW-1:0] out_data_next;
  logic [CW-1:0] cf_next;
  logic signed [DW:0] diff;
  logic signed [DW+CW+1:0] prod, scl;
  logic [DW-1:0] clip;

  ////////////////////////////////////////////////////////////////
  // correction path: offset aligned to the top, gain over 2^NFS
  always_comb begin
    diff = $signed({smp[DW-1], smp}) - $signed({off[CW-1], off, {(DW-CW){1'b0}}}); // R14
    prod = diff * $signed({1'b0, gain}); // R15
    scl = prod >>> NFS; // R21
    if (scl > $signed({{(CW+3){1'b0}}, {(DW-1){1'b1}}})) begin
      clip = {1'b0, {(DW-1){1'b1}}};
    end else if (scl < $signed({{(CW+3){1'b1}}, {(DW-1){1'b0}}})) begin
      clip = {1'b1, {(DW-1){1'b0}}};
    end else begin
      clip = scl[DW-1:0];
    end
  end

  assign busy = (st_reg != CAL_IDLE);

  ////////////////////////////////////////////////////////////////
  // averaging and coefficient division
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    acc_next = acc_reg;
    num_next = num_reg;
    q_next = q_reg;
    rem_next = rem_reg;
    dv_next = dv_reg;
    cf_vld_next = 1'b0;
    cf_next = cf;
    sum = acc_reg + $signed({{4{diff[DW]}}, diff});
    trial = {rem_reg[DW-1:0], num_reg[NW-1]};
    out_vld_next = smp_vld && !busy && !cal_go; // R25
    out_data_next = out_vld_next ? clip : out_data;
    unique case (st_reg)
      CAL_IDLE: begin
        if (cal_go) begin
          st_next = CAL_AVG;
          cnt_next = 7'h00;
          acc_next = '0;
        end
      end
      CAL_AVG: begin
        if (smp_vld) begin
          acc_next = sum; // R1 R3
          cnt_next = cnt_reg + 7'h01; // R12
          if (cnt_reg == 7'(CAL_AVG_N - 1)) begin
            st_next = CAL_DIV;
            cnt_next = 7'h00;
            dv_next = (sum >>> CAL_AVG_SHIFT) > 0 ? (DW+1)'(sum >>> CAL_AVG_SHIFT) : {{DW{1'b0}}, 1'b1};
            num_next = {{(DW-1){1'b1}}, {NFS{1'b0}}};
            q_next = '0;
            rem_next = '0;
          end
        end
      end
      CAL_DIV: begin
        if (trial >= dv_reg) begin
          rem_next = trial - dv_reg;
          q_next = {q_reg[NW-2:0], 1'b1};
        end else begin
          rem_next = trial;
          q_next = {q_reg[NW-2:0], 1'b0};
        end
        num_next = {num_reg[NW-2:0], 1'b0};
        cnt_next = cnt_reg + 7'h01;
        if (cnt_reg == 7'(NW - 1)) begin
          st_next = CAL_IDLE;
          cf_vld_next = 1'b1;
          cf_next = (|q_next[NW-1:CW]) ? {CW{1'b1}} : q_next[CW-1:0]; // R2 R3
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= CAL_IDLE;
      cnt_reg <= 7'h00;
      acc_reg <= '0;
      num_reg <= '0;
      q_reg <= '0;
      rem_reg <= '0;
      dv_reg <= '0;
      out_vld <= 1'b0;
      out_data <= '0;
      cf_vld <= 1'b0;
      cf <= '0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      acc_reg <= acc_next;
      num_reg <= num_next;
      q_reg <= q_next;
      rem_reg <= rem_next;
      dv_reg <= dv_next;
      out_vld <= out_vld_next;
      out_data <= out_data_next;
      cf_vld <= cf_vld_next;
      cf <= cf_next;
    end
  end

  ////////////////////////////////////////////////////////////////
  property p_avg16;
    @(posedge clk) disable iff (!rst_n)
    (st_reg == CAL_AVG && smp_vld && cnt_reg == 7'h0F) |=> (st_reg == CAL_DIV);
  endproperty
  a_avg16: assert property (p_avg16) else $error("averaging did not end after 16 samples"); // R1

  property p_div_len;
    @(posedge clk) disable iff (!rst_n)
    $rose(st_reg == CAL_DIV) |-> ##NW cf_vld;
  endproperty
  a_div_len: assert property (p_div_len) else $error("coefficient not delivered after division"); // R2

  property p_cf_src;
    @(posedge clk) disable iff (!rst_n)
    cf_vld |-> ($past(st_reg) == CAL_DIV) && (st_reg == CAL_IDLE);
  endproperty
  a_cf_src: assert property (p_cf_src) else $error("coefficient without calibration"); // R3

  property p_quiet;
    @(posedge clk) disable iff (!rst_n)
    busy |=> !out_vld;
  endproperty
  a_quiet: assert property (p_quiet) else $error("result presented during calibration"); // R25

  property p_unity;
    @(posedge clk) disable iff (!rst_n)
    (smp_vld && !busy && !cal_go && off == '0 && gain == CW'(1) << NFS) |=> (out_vld && out_data == $past(smp));
  endproperty
  a_unity: assert property (p_unity) else $error("unity coefficients changed the sample"); // R14 R15 R21
endmodule // acrc_cal_unit

// ---- rtl/acrc_top.sv ----
`timescale 1ns/1ps
// What this block does
// [R1] Primary gain calibration averages 16 readings before computing the coefficient.
// [R2] Primary gain coefficient maps applied input to positive full scale, 24-bit register.
// [R3] Auxiliary gain calibration averages 16 readings into the 16-bit auxiliary gain register.
// [R4] Host opens all inputs (mux FFh) before an offset self-calibration.
// [R5] Host calibrates offset before full scale, with a settled reference.
// [R6] Host selects continuous conversion before primary calibration.
// [R7] Host starts conversions before sending a calibration command.
// [R8] Calibration command starts calibration; primary one drives conversion_done_n high.
// [R9] Host keeps chip select and serial clock low during calibration.
// [R10] Primary calibration end writes coefficients, drives conversion_done_n low.
// [R11] Auxiliary calibration end has no indication; host waits the tabled time. Here status bit 2 (auxiliary busy) drops when it ends.
// [R12] Primary calibration length follows data rate and filter choice.
// [R13] Host presets offsets to zero, gains to unity before user calibration.
// [R14] Offset coefficient is subtracted from every conversion result.
// [R15] Gain is straight binary, unity at 400000h primary and 4000h auxiliary.
// [R16] Power-on, pin or command reset restores defaults and restarts conversions.
// [R17] Any reset sets the reset flag in status bit 0 and power bit 4.
// [R18] Writing 0 clears the reset flag; a later 1 means a new reset.
// [R19] Device leaves reset 65536 master clocks after supplies pass thresholds.
// [R20] Host waits at least 9 ms after power-up before talking.
// [R21] Output is (filter minus offset) times gain over 400000h, clipped to 32 bits.
// [R22] Pin low for 4 clocks resets; beyond 65536 clocks enters power-down.
// [R23] Reset command opcode is 06h or 07h.
// [R24] Primary system gain calibration opcode is 17h.
// [R25] No intermediate averaged readings appear as results during calibration.
module acrc_top
  import acrc_pkg::*;
#(
  parameter int POR_CYC = POR_TICKS,
  parameter int PWDN_CYC = PWDN_TICKS
) (
  input wire logic REF_CLK_IN,
  input wire logic RESETN_IN,
  input wire logic [7:0] S_AXI_AWADDR_IN,
  input wire logic S_AXI_AWVALID_IN,
  output logic S_AXI_AWREADY_OUT,
  input wire logic [31:0] S_AXI_WDATA_IN,
  input wire logic [3:0] S_AXI_WSTRB_IN,
  input wire logic S_AXI_WVALID_IN,
  output logic S_AXI_WREADY_OUT,
  output logic [1:0] S_AXI_BRESP_OUT,
  output logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  input wire logic [7:0] S_AXI_ARADDR_IN,
  input wire logic S_AXI_ARVALID_IN,
  output logic S_AXI_ARREADY_OUT,
  output logic [31:0] S_AXI_RDATA_OUT,
  output logic [1:0] S_AXI_RRESP_OUT,
  output logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN,
  input wire logic MCLK_IN,
  input wire logic SUPPLY_OK_IN,
  input wire logic RESET_POWERDOWN_PIN_N_IN,
  input wire logic PRI_SMP_VLD_IN,
  input wire logic [31:0] PRI_SMP_IN,
  input wire logic AUX_SMP_VLD_IN,
  input wire logic [23:0] AUX_SMP_IN,
  output logic CONVERSION_DONE_N_OUT,
  output logic [31:0] PRI_DATA_OUT,
  output logic [23:0] AUX_DATA_OUT,
  output logic CONV_RESTART_OUT,
  output logic OPERATIONAL_OUT,
  output logic POWERDOWN_OUT
);
  if (POR_CYC < 1 || POR_CYC > 131071 || PWDN_CYC <= RST_MIN_TICKS || PWDN_CYC > 131071)
    $error("acrc_top: tick counts out of range");

  function automatic logic fn_mapped(input logic [7:0] a);
    return a == ADDR_CMD || a == ADDR_STATUS || a == ADDR_POWER || a == ADDR_P_OFF || a == ADDR_P_GAIN ||
      a == ADDR_A_OFF || a == ADDR_A_GAIN || a == ADDR_P_DATA || a == ADDR_A_DATA;
  endfunction

  function automatic logic [31:0] fn_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////
  // pin synchronisers and reset sequencing
  logic mclk_m_reg, mclk_s_reg, mclk_d_reg, pin_m_reg, pin_s_reg, sup_m_reg, sup_s_reg;
  acrc_rst_st_t rs_reg, rs_next;
  logic [16:0] rs_cnt_reg, rs_cnt_next;
  logic dev_rst_reg, dev_rst_next, tick, soft_rst, run, cmd_rst;

  assign tick = mclk_s_reg && !mclk_d_reg;
  assign run = (rs_reg == RS_RUN);
  assign soft_rst = !RESETN_IN || dev_rst_reg || rs_reg == RS_POR || rs_reg == RS_PWDN; // R16

  always_comb begin
    rs_next = rs_reg;
    rs_cnt_next = rs_cnt_reg;
    dev_rst_next = cmd_rst; // R23
    unique case (rs_reg)
      RS_POR: begin
        if (!sup_s_reg) begin
          rs_cnt_next = 17'h00000;
        end else if (tick) begin
          rs_cnt_next = rs_cnt_reg + 17'h00001;
          if (rs_cnt_reg == 17'(POR_CYC - 1)) begin
            rs_next = RS_RUN; // R19
            dev_rst_next = 1'b1;
          end
        end
      end
      RS_RUN: begin
        rs_cnt_next = 17'h00000;
        if (!sup_s_reg) begin
          rs_next = RS_POR;
        end else if (!pin_s_reg) begin
          rs_next = RS_PINLOW;
        end
      end
      RS_PINLOW: begin
        if (pin_s_reg) begin
          rs_next = RS_RUN;
          dev_rst_next = (rs_cnt_reg >= 17'(RST_MIN_TICKS)); // R22
        end else if (tick) begin
          rs_cnt_next = rs_cnt_reg + 17'h00001;
          if (rs_cnt_reg == 17'(PWDN_CYC - 1)) begin
            rs_next = RS_PWDN; // R22
          end
        end
      end
      RS_PWDN: begin
        rs_cnt_next = 17'h00000;
        if (pin_s_reg) begin
          rs_next = RS_POR;
        end
      end
    endcase
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RESETN_IN) begin
      mclk_m_reg <= 1'b0;
      mclk_s_reg <= 1'b0;
      mclk_d_reg <= 1'b0;
      pin_m_reg <= 1'b1;
      pin_s_reg <= 1'b1;
      sup_m_reg <= 1'b0;
      sup_s_reg <= 1'b0;
      rs_reg <= RS_POR;
      rs_cnt_reg <= 17'h00000;
      dev_rst_reg <= 1'b0;
    end else begin
      mclk_m_reg <= MCLK_IN;
      mclk_s_reg <= mclk_m_reg;
      mclk_d_reg <= mclk_s_reg;
      pin_m_reg <= RESET_POWERDOWN_PIN_N_IN;
      pin_s_reg <= pin_m_reg;
      sup_m_reg <= SUPPLY_OK_IN;
      sup_s_reg <= sup_m_reg;
      rs_reg <= rs_next;
      rs_cnt_reg <= rs_cnt_next;
      dev_rst_reg <= dev_rst_next;
    end
  end

  assign CONV_RESTART_OUT = dev_rst_reg; // R16
  assign OPERATIONAL_OUT = run;
  assign POWERDOWN_OUT = (rs_reg == RS_PWDN);

  ////////////////////////////////////////////////////////////////
  // register bus slave
  logic aw_have_reg, aw_have_next, w_have_reg, w_have_next, bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next, rdata_reg, rdata_next, rword;
  logic [3:0] wstrb_reg, wstrb_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic wr_do, op_we, p_go, a_go, rd_pdata;
  acrc_coeff_t cr_reg, cr_next;
  logic flag_reg, flag_next, done_n_reg, done_n_next;
  logic p_out_vld, p_busy, p_cf_vld, a_busy, a_cf_vld;
  logic [23:0] p_cf;
  logic [15:0] a_cf;

  assign S_AXI_AWREADY_OUT = !aw_have_reg && !bvalid_reg;
  assign S_AXI_WREADY_OUT = !w_have_reg && !bvalid_reg;
  assign S_AXI_ARREADY_OUT = !rvalid_reg;
  assign wr_do = aw_have_reg && w_have_reg && !bvalid_reg;
  assign op_we = wr_do && run && awaddr_reg == ADDR_CMD && wstrb_reg[0];
  assign p_go = op_we && wdata_reg[7:0] == OP_P_GCAL; // R24
  assign a_go = op_we && wdata_reg[7:0] == OP_A_GCAL;
  assign cmd_rst = op_we && (wdata_reg[7:0] == OP_RESET_A || wdata_reg[7:0] == OP_RESET_B); // R23
  assign rd_pdata = S_AXI_ARVALID_IN && !rvalid_reg && S_AXI_ARADDR_IN == ADDR_P_DATA;

  always_comb begin
    aw_have_next = aw_have_reg;
    awaddr_next = awaddr_reg;
    w_have_next = w_have_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    rword = 32'h00000000;
    unique case (S_AXI_ARADDR_IN)
      ADDR_STATUS: rword = {29'h00000000, a_busy, p_busy, flag_reg}; // R17
      ADDR_POWER: rword = {27'h0000000, flag_reg, 4'h0}; // R17
      ADDR_P_OFF: rword = {8'h00, cr_reg.p_off};
      ADDR_P_GAIN: rword = {8'h00, cr_reg.p_gain};
      ADDR_A_OFF: rword = {16'h0000, cr_reg.a_off};
      ADDR_A_GAIN: rword = {16'h0000, cr_reg.a_gain};
      ADDR_P_DATA: rword = PRI_DATA_OUT;
      ADDR_A_DATA: rword = {8'h00, AUX_DATA_OUT};
      default: rword = 32'h00000000;
    endcase
    if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
      aw_have_next = 1'b1;
      awaddr_next = S_AXI_AWADDR_IN;
    end
    if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
      w_have_next = 1'b1;
      wdata_next = S_AXI_WDATA_IN;
      wstrb_next = S_AXI_WSTRB_IN;
    end
    if (wr_do) begin
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = fn_mapped(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_reg && S_AXI_BREADY_IN) begin
      bvalid_next = 1'b0;
    end
    if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
      rvalid_next = 1'b1;
      rdata_next = rword;
      rresp_next = fn_mapped(S_AXI_ARADDR_IN) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && S_AXI_RREADY_IN) begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RESETN_IN) begin
      aw_have_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      w_have_reg <= 1'b0;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= RESP_OKAY;
    end else begin
      aw_have_reg <= aw_have_next;
      awaddr_reg <= awaddr_next;
      w_have_reg <= w_have_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  assign S_AXI_BVALID_OUT = bvalid_reg;
  assign S_AXI_BRESP_OUT = bresp_reg;
  assign S_AXI_RVALID_OUT = rvalid_reg;
  assign S_AXI_RDATA_OUT = rdata_reg;
  assign S_AXI_RRESP_OUT = rresp_reg;

  ////////////////////////////////////////////////////////////////
  // coefficients, reset flag and conversion-done strobe
  always_comb begin
    cr_next = cr_reg;
    flag_next = flag_reg;
    done_n_next = done_n_reg;
    if (wr_do && run) begin
      unique case (awaddr_reg)
        ADDR_POWER: begin
          if (wstrb_reg[0] && !wdata_reg[POWER_FLAG_BIT]) flag_next = 1'b0; // R18
        end
        ADDR_P_OFF: cr_next.p_off = 24'(fn_merge({8'h00, cr_reg.p_off}, wdata_reg, wstrb_reg));
        ADDR_P_GAIN: cr_next.p_gain = 24'(fn_merge({8'h00, cr_reg.p_gain}, wdata_reg, wstrb_reg));
        ADDR_A_OFF: cr_next.a_off = 16'(fn_merge({16'h0000, cr_reg.a_off}, wdata_reg, wstrb_reg));
        ADDR_A_GAIN: cr_next.a_gain = 16'(fn_merge({16'h0000, cr_reg.a_gain}, wdata_reg, wstrb_reg));
        default: ;
      endcase
    end
    if (p_out_vld) done_n_next = 1'b0;
    if (rd_pdata) done_n_next = 1'b1;
    if (p_cf_vld) begin
      cr_next.p_gain = p_cf; // R10
      done_n_next = 1'b0; // R10
    end
    if (a_cf_vld) cr_next.a_gain = a_cf; // R3 R11
    if (p_go && !p_busy) done_n_next = 1'b1; // R8
    if (soft_rst) begin
      cr_next = '{P_OFF_RST, P_GAIN_RST, A_OFF_RST, A_GAIN_RST}; // R16
      flag_next = 1'b1; // R17
      done_n_next = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RESETN_IN) begin
      cr_reg <= '{P_OFF_RST, P_GAIN_RST, A_OFF_RST, A_GAIN_RST};
      flag_reg <= 1'b1;
      done_n_reg <= 1'b1;
    end else begin
      cr_reg <= cr_next;
      flag_reg <= flag_next;
      done_n_reg <= done_n_next;
    end
  end

  assign CONVERSION_DONE_N_OUT = done_n_reg;

  acrc_cal_unit #(.DW(P_DW), .CW(P_CW), .NFS(P_NFS)) u_pri (
    .clk(REF_CLK_IN),
    .rst_n(!soft_rst),
    .smp_vld(PRI_SMP_VLD_IN),
    .smp(PRI_SMP_IN),
    .off(cr_reg.p_off),
    .gain(cr_reg.p_gain),
    .cal_go(p_go),
    .out_vld(p_out_vld),
    .out_data(PRI_DATA_OUT),
    .busy(p_busy),
    .cf_vld(p_cf_vld),
    .cf(p_cf)
  );

  acrc_cal_unit #(.DW(A_DW), .CW(A_CW), .NFS(A_NFS)) u_aux (
    .clk(REF_CLK_IN),
    .rst_n(!soft_rst),
    .smp_vld(AUX_SMP_VLD_IN),
    .smp(AUX_SMP_IN),
    .off(cr_reg.a_off),
    .gain(cr_reg.a_gain),
    .cal_go(a_go),
    .out_vld(),
    .out_data(AUX_DATA_OUT),
    .busy(a_busy),
    .cf_vld(a_cf_vld),
    .cf(a_cf)
  );

  ////////////////////////////////////////////////////////////////
  property p_conversion_done_n_start;
    @(posedge REF_CLK_IN) disable iff (!RESETN_IN)
    (p_go && !p_busy) |=> CONVERSION_DONE_N_OUT;
  endproperty
  a_conversion_done_n_start: assert property (p_conversion_done_n_start) else $error("done_n not high at calibration start"); // R8

  property p_conversion_done_n_end;
    @(posedge REF_CLK_IN) disable iff (!RESETN_IN)
    (p_cf_vld && !soft_rst && !p_go && !rd_pdata) |=> (!CONVERSION_DONE_N_OUT && cr_reg.p_gain == $past(p_cf));
  endproperty
  a_conversion_done_n_end: assert property (p_conversion_done_n_end) else $error("calibration end not signalled"); // R10

  property p_flag_set;
    @(posedge REF_CLK_IN) disable iff (!RESETN_IN)
    dev_rst_reg |=> (flag_reg && cr_reg.p_gain == P_GAIN_RST && cr_reg.a_gain == A_GAIN_RST);
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("reset did not restore defaults and flag"); // R16 R17

  property p_flag_clr;
    @(posedge REF_CLK_IN) disable iff (!RESETN_IN)
    (wr_do && run && !soft_rst && awaddr_reg == ADDR_POWER && wstrb_reg[0] && !wdata_reg[POWER_FLAG_BIT])
      |=> !flag_reg;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("reset flag not cleared"); // R18

  property p_cmd_rst;
    @(posedge REF_CLK_IN) disable iff (!RESETN_IN)
    cmd_rst |=> dev_rst_reg ##1 flag_reg;
  endproperty
  a_cmd_rst: assert property (p_cmd_rst) else $error("reset command ignored"); // R23

  property p_glitch;
    @(posedge REF_CLK_IN) disable iff (!RESETN_IN)
    (rs_reg == RS_PINLOW && pin_s_reg && rs_cnt_reg < 17'(RST_MIN_TICKS)) |=> (!dev_rst_reg && run);
  endproperty
  a_glitch: assert property (p_glitch) else $error("short pin pulse caused a reset"); // R22

  property p_por_hold;
    @(posedge REF_CLK_IN) disable iff (!RESETN_IN)
    !sup_s_reg |=> !OPERATIONAL_OUT;
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("operational without supplies"); // R19
endmodule // acrc_top

// ---- sim/acrc_conv_model.sv ----
`timescale 1ns/1ps
module acrc_conv_model (
  input wire logic clk_in,
  input wire logic pri_en_in,
  input wire logic [31:0] pri_val_in,
  input wire logic aux_en_in,
  input wire logic [23:0] aux_val_in,
  output logic mclk_out,
  output logic pri_vld_out,
  output logic [31:0] pri_smp_out,
  output logic aux_vld_out,
  output logic [23:0] aux_smp_out
);
  logic [2:0] cnt_reg = 3'h0;
  initial begin
    {pri_vld_out, aux_vld_out, pri_smp_out, aux_smp_out} = '0;
    mclk_out = 1'b0;
    forever #80 mclk_out = ~mclk_out;
  end
  // conversions run only once started
  always @(posedge clk_in) begin
    cnt_reg <= cnt_reg + 3'h1;
    pri_vld_out <= pri_en_in && cnt_reg == 3'h0;
    aux_vld_out <= aux_en_in && cnt_reg == 3'h4;
    pri_smp_out <= pri_val_in;
    aux_smp_out <= aux_val_in;
  end
endmodule // acrc_conv_model

// ---- sim/acrc_top_tb.sv ----
`timescale 1ns/1ps
module acrc_top_tb;
  import acrc_pkg::*;
  logic clk, rst_n, awv, wv, bready, arv, rready, pin_n, pri_en, aux_en;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, pri_val, rd_d, rdata, pdata, psmp;
  logic [23:0] aux_val, adata, asmp;
  logic [1:0] rd_r, wr_r, bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, done_n, op, pd, mclk, pvld, avld, rst_o, sup;
  int mismatches = 0;
  int n_compared = 0;
  int n_rst = 0;
  logic [7:0] ops [2] = '{8'h06, 8'h07};
  acrc_top #(.POR_CYC(20), .PWDN_CYC(40)) i_dut (.REF_CLK_IN(clk), .RESETN_IN(rst_n),
    .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awready),
    .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(4'hF), .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wready),
    .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
    .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arready),
    .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready),
    .MCLK_IN(mclk), .SUPPLY_OK_IN(sup), .RESET_POWERDOWN_PIN_N_IN(pin_n), .PRI_SMP_VLD_IN(pvld),
    .PRI_SMP_IN(psmp), .AUX_SMP_VLD_IN(avld), .AUX_SMP_IN(asmp), .CONVERSION_DONE_N_OUT(done_n),
    .PRI_DATA_OUT(pdata), .AUX_DATA_OUT(adata), .CONV_RESTART_OUT(rst_o), .OPERATIONAL_OUT(op),
    .POWERDOWN_OUT(pd));
  acrc_conv_model i_conv (.clk_in(clk), .pri_en_in(pri_en), .pri_val_in(pri_val), .aux_en_in(aux_en),
    .aux_val_in(aux_val), .mclk_out(mclk), .pri_vld_out(pvld), .pri_smp_out(psmp),
    .aux_vld_out(avld), .aux_smp_out(asmp));
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clk);
      if (awv && awready === 1'b1) begin
        ad = 1'b1;
        awv <= 1'b0;
      end
      if (wv && wready === 1'b1) begin
        wd = 1'b1;
        wv <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge clk); while (bvalid !== 1'b1);
    wr_r = bresp;
    bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    araddr <= a;
    arv <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arv <= 1'b0;
    rready <= 1'b1;
    do @(posedge clk); while (rvalid !== 1'b1);
    rd_d = rdata;
    rd_r = rresp;
    rready <= 1'b0;
  endtask
  // wait for a status busy bit to drop, bounded
  task poll(input int b);
    for (int k = 0; k < 200; k++) begin
      rd(ADDR_STATUS);
      if (rd_d[b] === 1'b0) break;
    end
  endtask
  task wrap_up;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // counts device restart pulses
  always @(posedge clk) if (rst_o === 1'b1) n_rst++;
  initial begin
    #200000;
    mismatches++;
    wrap_up();
  end
  initial begin
    {rst_n, sup, awv, wv, bready, arv, rready, pri_en, aux_en, awaddr, araddr, wdata} = '0;
    {pri_val, aux_val} = '0;
    pin_n = 1'b1;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (100) @(posedge clk);
    sup <= 1'b1;
    repeat (240) @(posedge clk);
    chk("oper_early", 32'h0, op);
    repeat (200) @(posedge clk);
    chk("oper", 32'h1, op);
    rd(ADDR_STATUS);
    chk("st_flag", 32'h1, rd_d[0]);
    rd(ADDR_P_GAIN);
    chk("p_gain", 32'h400000, rd_d);
    wr(ADDR_POWER, 32'h0);
    rd(ADDR_STATUS);
    chk("flag_clr", 32'h0, rd_d[0]);
    wr(ADDR_P_OFF, 32'h1);
    chk("wresp", 32'h0, wr_r);
    pri_val <= 32'h3E8;
    pri_en <= 1'b1;
    repeat (20) @(posedge clk);
    chk("p_data", 32'h2E8, pdata);
    chk("done_lo", 32'h0, done_n);
    for (int i = 0; i < 2; i++) begin
      wr(ADDR_POWER, 32'h0);
      wr(ADDR_P_OFF, 32'h5);
      wr(ADDR_CMD, {24'h0, ops[i]});
      rd(ADDR_P_OFF);
      chk("off_rst", 32'h0, rd_d);
      rd(ADDR_POWER);
      chk("pw_flag", 32'h1, rd_d[4]);
    end
    pri_val <= 32'h40000000;
    repeat (20) @(posedge clk);
    wr(ADDR_P_GAIN, 32'h400000);
    wr(ADDR_CMD, 32'h17);
    chk("cal_done_hi", 32'h1, done_n);
    poll(1);
    rd(ADDR_P_GAIN);
    chk("p_gcoef", 32'h7FFFFF, rd_d);
    repeat (20) @(posedge clk);
    chk("p_new", 32'h7FFFFF00, pdata);
    chk("cal_done_lo", 32'h0, done_n);
    aux_val <= 24'h400000;
    aux_en <= 1'b1;
    repeat (20) @(posedge clk);
    wr(ADDR_CMD, 32'h1C);
    poll(2);
    rd(ADDR_A_GAIN);
    chk("a_gcoef", 32'h7FFF, rd_d);
    repeat (20) @(posedge clk);
    chk("a_new", 32'h7FFF00, adata);
    rd(8'h40);
    chk("unm_resp", 32'h2, rd_r);
    chk("unm_data", 32'h0, rd_d);
    wr(8'h40, 32'h1);
    chk("unm_wresp", 32'h2, wr_r);
    wr(ADDR_POWER, 32'h0);
    pin_n <= 1'b0;
    repeat (128) @(posedge clk);
    pin_n <= 1'b1;
    repeat (200) @(posedge clk);
    chk("no_pwdn", 32'h0, pd);
    rd(ADDR_STATUS);
    chk("pin_flag", 32'h1, rd_d[0]);
    pin_n <= 1'b0;
    repeat (700) @(posedge clk);
    chk("pwdn", 32'h1, pd);
    pin_n <= 1'b1;
    repeat (400) @(posedge clk);
    chk("pwdn_exit", 32'h1, op);
    chk("restarts", 32'h5, n_rst);
    wrap_up();
  end
endmodule // acrc_top_tb
